// ### shared/ctsc_pkg.sv
// constants shared by the tag store controller and its pin sequencer
// assumes a 250 MHz clock and a clockless tag store device on the pins
`default_nettype none
package ctsc_pkg;
  localparam int unsigned CTSC_CLK_PERIOD_PS = 4000; // 250 MHz clock
  localparam int unsigned CTSC_RESET_MIN_PS = 35000; // least reset low pulse
  // least time rounds up to whole cycles
  localparam int unsigned CTSC_RESET_CYC =
    (CTSC_RESET_MIN_PS + CTSC_CLK_PERIOD_PS - 1) / CTSC_CLK_PERIOD_PS;
  localparam int unsigned CTSC_SETTLE_CYC_DEF = 25; // compare settle time, cycles
  localparam int unsigned CTSC_WRITE_CYC_DEF = 12; // write pulse width, cycles
  localparam int unsigned CTSC_INDEX_W = 9; // index pins
  localparam int unsigned CTSC_TAG_W = 8; // tag slice width
  localparam int unsigned CTSC_CNT_W = 8; // timer width
  localparam logic [CTSC_CNT_W-1:0] CTSC_CNT_ONE = 8'h01;
  typedef enum logic [1:0] {CTSC_OP_NONE, CTSC_OP_CMP, CTSC_OP_WR, CTSC_OP_CLR} ctsc_op_type;
endpackage
`default_nettype wire

// ### rtl/ctsc_timer.sv
// down counter that times each pin phase of the controller
// assumes load and load value come from the controller state machine
`timescale 1ns/1ps
`default_nettype none
module ctsc_timer
  import ctsc_pkg::*;
#(
  parameter int unsigned W = CTSC_CNT_W
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_r; // remaining cycles

  // ************************************************
  // count down to zero after each load
  // ************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
    end
    else if (load)
    begin
      cnt_r <= load_val;
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // done while expired; load is kept out so the caller may load on done
  // without a combinational loop through this output
  assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// ### rtl/ctsc_host.sv
// controller that drives a clockless cache tag store and comparator
// through its pins: select, write control, reset, index, tag and the
// shared open-collector parity error line.
// assumes the device pins settle within the settle count; all inputs
// are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - device holds 512 nine-bit tag entries
// RULE2 - reset low at least 35 ns clears
// RULE3 - compare: select low, write control high
// RULE4 - index picks entry; compared with tag
// RULE5 - equal entry drives hit high
// RULE6 - parity failure drives error and hit low
// RULE7 - error line only pulled low, wired-or
// RULE8 - select and write low store tag
// RULE9 - error line forced low for testing
// RULE10 - stored tags never driven on pins
// RULE11 - 8-bit slice; hits combined externally
// RULE12 - device is static, no clock needed
// RULE13 - select high means no write
module ctsc_host
  import ctsc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = CTSC_SETTLE_CYC_DEF,
  parameter int unsigned WRITE_CYC = CTSC_WRITE_CYC_DEF,
  parameter int unsigned SLICES = 1
)
(
  input wire logic clk,
  input wire logic arst_n,
  // user side
  input wire logic req_valid,
  input wire ctsc_op_type req_op,
  input wire logic [CTSC_INDEX_W-1:0] req_index,
  input wire logic [SLICES*CTSC_TAG_W-1:0] req_tag,
  input wire logic force_err,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic rsp_perr,
  // device pins
  output logic dev_sel_n,
  output logic dev_wr_n,
  output logic dev_reset_n,
  output logic [CTSC_INDEX_W-1:0] tag_index,
  output logic [SLICES*CTSC_TAG_W-1:0] tag_compare_bits,
  input wire logic [SLICES-1:0] dev_hit,
  input wire logic parity_error_n_in,
  output logic parity_error_n_out,
  output logic parity_error_n_oe
);
  // ************************************************
  // state and local signals
  // ************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_CMP, ST_WSET, ST_WPULSE, ST_CLR, ST_REC} ctsc_state_type;
  ctsc_state_type state_r; // sequencer state
  ctsc_state_type state_nxt; // next state
  logic tmr_load; // start phase timer
  logic [CTSC_CNT_W-1:0] tmr_val; // phase length
  logic tmr_done; // phase over
  logic all_hit; // combined slice hits
  logic [SLICES-1:0] hit_vec; // per slice hit
  logic take; // request accepted at this edge, only while ready
  assign take = (state_r == ST_IDLE) && req_valid && req_ready;

  ctsc_timer #(.W(CTSC_CNT_W)) u_tmr (
    .clk(clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ************************************************
  // slice hit combine
  // ************************************************
  // every slice must match for a full tag hit [RULE11]
  genvar gi;
  generate
    for (gi = 0; gi < SLICES; gi++)
    begin : g_slice
      assign hit_vec[gi] = dev_hit[gi];
    end
  endgenerate
  assign all_hit = &hit_vec; // [RULE11]

  // ************************************************
  // sequencer next state and timer loads
  // ************************************************
  // the device has no clock, so each phase is timed here [RULE12]
  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = CTSC_CNT_ONE;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          case (req_op)
            CTSC_OP_CMP:
            begin
              state_nxt = ST_CMP;
              tmr_load = 1'b1;
              tmr_val = CTSC_CNT_W'(SETTLE_CYC);
            end
            CTSC_OP_WR:
            begin
              state_nxt = ST_WSET;
              tmr_load = 1'b1;
              tmr_val = CTSC_CNT_ONE;
            end
            CTSC_OP_CLR:
            begin
              state_nxt = ST_CLR;
              tmr_load = 1'b1;
              tmr_val = CTSC_CNT_W'(CTSC_RESET_CYC);
            end
            default:
            begin
              state_nxt = ST_IDLE; // no operation
            end
          endcase
        end
      end
      ST_CMP:
      begin
        if (tmr_done)
        begin
          state_nxt = ST_REC;
          tmr_load = 1'b1;
        end
      end
      ST_WSET:
      begin
        // address settled before write strobe falls
        if (tmr_done)
        begin
          state_nxt = ST_WPULSE;
          tmr_load = 1'b1;
          tmr_val = CTSC_CNT_W'(WRITE_CYC);
        end
      end
      ST_WPULSE:
      begin
        if (tmr_done)
        begin
          state_nxt = ST_REC;
          tmr_load = 1'b1;
        end
      end
      ST_CLR:
      begin
        if (tmr_done)
        begin
          state_nxt = ST_REC;
          tmr_load = 1'b1;
        end
      end
      ST_REC:
      begin
        // two recovery cycles with select high between operations
        if (tmr_done)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ************************************************
  // device control pins
  // ************************************************
  // select and write control come straight from flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dev_sel_n <= 1'b1;
      dev_wr_n <= 1'b1;
      dev_reset_n <= 1'b1;
    end
    else
    begin
      // compare: select low with write control high [RULE3]
      // write: both low only in the pulse phase [RULE8]
      // otherwise select high so no write can occur [RULE13]
      dev_sel_n <= !(state_nxt == ST_CMP || state_nxt == ST_WSET || state_nxt == ST_WPULSE);
      dev_wr_n <= !(state_nxt == ST_WPULSE); // [RULE8]
      // clear pulse held at least the least reset width [RULE2]
      dev_reset_n <= !(state_nxt == ST_CLR);
    end
  end

  // ************************************************
  // index and tag pins
  // ************************************************
  // tag pins are only ever driven by us; stored tags never come back [RULE10]
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tag_index <= '0;
      tag_compare_bits <= '0;
    end
    else if (take)
    begin
      tag_index <= req_index; // entry pick, 512 deep [RULE1] [RULE4]
      tag_compare_bits <= req_tag; // [RULE4]
    end
  end

  // ************************************************
  // shared error line, test force
  // ************************************************
  // pulled low only, never driven high, wired-or safe [RULE7]
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      parity_error_n_out <= 1'b0;
      parity_error_n_oe <= 1'b1;
    end
    else
    begin
      parity_error_n_out <= 1'b0;
      parity_error_n_oe <= !force_err; // low enable drives low [RULE9]
    end
  end

  // ************************************************
  // compare result capture
  // ************************************************
  // sampled at the end of the settle time, hit low on error [RULE5] [RULE6]
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_perr <= 1'b0;
    end
    else if (state_r == ST_CMP && tmr_done)
    begin
      rsp_valid <= 1'b1;
      rsp_perr <= !parity_error_n_in; // [RULE6] [RULE9]
      rsp_hit <= all_hit && parity_error_n_in; // [RULE5]
    end
    else
    begin
      rsp_valid <= 1'b0;
    end
  end

  // ************************************************
  // request ready
  // ************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_ready <= 1'b0;
    end
    else
    begin
      req_ready <= (state_nxt == ST_IDLE) && !take;
    end
  end
endmodule
`default_nettype wire

// ### rtl/ctsc_unused_placeholder_none.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/ctsc_asserts.sv
// pin and response checks for the tag store controller
// assumes it is bound onto ctsc_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ctsc_asserts
  import ctsc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 2
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire ctsc_op_type req_op,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_hit,
  input wire logic rsp_perr,
  input wire logic dev_sel_n,
  input wire logic dev_wr_n,
  input wire logic dev_reset_n,
  input wire logic [CTSC_INDEX_W-1:0] tag_index,
  input wire logic parity_error_n_out,
  input wire logic parity_error_n_oe
);
  // *****
  // properties
  // *****
  localparam int RSP_LO = SETTLE_CYC + 1; // response lands one edge late at most
  localparam int RSP_HI = SETTLE_CYC + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a request taken at this edge
  sequence s_take(ctsc_op_type op);
    req_valid && req_ready && req_op == op;
  endsequence
  chk_cmp_pins: assert property (s_take(CTSC_OP_CMP) |=> (!dev_sel_n && dev_wr_n) [*2])
    else $error("compare pins wrong");
  chk_wr_pins: assert property (s_take(CTSC_OP_WR) |=> !dev_sel_n ##[1:2] (!dev_wr_n) [*2])
    else $error("write pins wrong");
  chk_clr_width: assert property (s_take(CTSC_OP_CLR) |-> ##[1:2] (!dev_reset_n) [*8] ##1 !dev_reset_n)
    else $error("clear pulse too short");
  chk_rsp_time: assert property (s_take(CTSC_OP_CMP) |-> ##[RSP_LO:RSP_HI] rsp_valid)
    else $error("compare response late");
  chk_index_hold: assert property (!dev_sel_n && $past(!dev_sel_n) |-> $stable(tag_index))
    else $error("index moved while selected");
  chk_wr_sel: assert property (!dev_wr_n |-> !dev_sel_n)
    else $error("write strobe without select");
  chk_oe_low: assert property (!parity_error_n_oe |-> !parity_error_n_out)
    else $error("error line driven high");
  chk_hit_perr: assert property (rsp_valid && rsp_perr |-> !rsp_hit)
    else $error("hit with parity error");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response not one cycle");
endmodule
bind ctsc_host ctsc_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk(clk), .arst_n(arst_n),
  .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_hit(rsp_hit), .rsp_perr(rsp_perr), .dev_sel_n(dev_sel_n), .dev_wr_n(dev_wr_n),
  .dev_reset_n(dev_reset_n), .tag_index(tag_index), .parity_error_n_out(parity_error_n_out),
  .parity_error_n_oe(parity_error_n_oe));
`default_nettype wire

// ### tb/ctsc_tag_model.sv
// behavioural clockless tag store slice on the far side of the pins
// assumes the bench resolves the shared error line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ctsc_tag_model
  import ctsc_pkg::*;
(
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic reset_n,
  input wire logic [CTSC_INDEX_W-1:0] index,
  input wire logic [CTSC_TAG_W-1:0] tag,
  input wire logic err_line_n,
  output logic hit,
  output logic err_n
);
  logic [8:0] mem [512]; // tag plus parity, data pins are inputs only
  logic [8:0] word;
  // power-up garbage with bad parity, so a missing clear shows
  initial
  begin
    foreach (mem[i]) mem[i] = 9'h1aa;
  end
  // asynchronous clear, no clock anywhere
  always @(negedge reset_n)
  begin
    foreach (mem[i]) mem[i] = 9'h000;
  end
  // store with even parity only while selected
  always @*
  begin
    if (reset_n && !sel_n && !wr_n)
      mem[index] = {^tag, tag};
  end
  assign word = mem[index];
  // pull low only on a bad stored word
  assign err_n = (reset_n && !sel_n && wr_n && ^word) ? 1'b0 : 1'b1;
  // forced error line kills the hit
  assign hit = !reset_n | (!sel_n & wr_n & err_line_n & (word == {^tag, tag}));
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the tag store controller
// assumes one slice, short settle and write counts
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ctsc_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  ctsc_op_type req_op = CTSC_OP_NONE;
  logic [8:0] req_index = 9'h000;
  logic [7:0] req_tag = 8'h00;
  logic force_err = 1'b0;
  logic req_ready, rsp_valid, rsp_hit, rsp_perr, sel_n, wr_n, rst_n, pe_out, pe_oe, dev_pe_n;
  logic [8:0] tag_index;
  logic [7:0] tag_bits;
  logic [0:0] dev_hit;
  wire logic pe_wire; // pull-up, either party may sink it
  int fail_count = 0;
  int n_tests = 0;
  assign pe_wire = dev_pe_n & (pe_oe ? 1'b1 : pe_out);
  always #2 clk = ~clk;
  ctsc_host #(.SETTLE_CYC(2), .WRITE_CYC(2)) uut (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_op(req_op), .req_index(req_index), .req_tag(req_tag),
    .force_err(force_err), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
    .rsp_perr(rsp_perr), .dev_sel_n(sel_n), .dev_wr_n(wr_n), .dev_reset_n(rst_n),
    .tag_index(tag_index), .tag_compare_bits(tag_bits), .dev_hit(dev_hit),
    .parity_error_n_in(pe_wire), .parity_error_n_out(pe_out), .parity_error_n_oe(pe_oe));
  ctsc_tag_model dev (.sel_n(sel_n), .wr_n(wr_n), .reset_n(rst_n), .index(tag_index),
    .tag(tag_bits), .err_line_n(pe_wire), .hit(dev_hit[0]), .err_n(dev_pe_n));
  // *****
  // helpers
  // *****
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // hold the request until an edge sees ready; reads before that edge's updates
  task automatic do_op(input ctsc_op_type op, input logic [8:0] idx, input logic [7:0] tag);
    int i;
    i = 0;
    req_op <= op;
    req_index <= idx;
    req_tag <= tag;
    req_valid <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (req_ready !== 1'b1 && i < 300);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
    // one edge between calls, so valid is never driven twice in one step
    @(posedge clk);
  endtask
  task automatic cmp(input logic [8:0] idx, input logic [7:0] tag, input logic [1:0] exp);
    int i;
    i = 0;
    do_op(CTSC_OP_CMP, idx, tag);
    while (rsp_valid !== 1'b1 && i < 50)
    begin
      @(posedge clk);
      i++;
    end
    if (rsp_valid !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
    check({rsp_hit, rsp_perr}, exp);
    @(posedge clk);
  endtask
  // *****
  // scenarios
  // *****
  task automatic s_clear();
    cmp(9'h000, 8'haa, 2'h1);
    do_op(CTSC_OP_CLR, 9'h000, 8'h00);
    cmp(9'h000, 8'h00, 2'h2);
    cmp(9'h1ff, 8'h00, 2'h2);
    cmp(9'h005, 8'h01, 2'h0);
  endtask
  task automatic s_write();
    do_op(CTSC_OP_WR, 9'h000, 8'ha5);
    do_op(CTSC_OP_WR, 9'h1ff, 8'h5a);
    do_op(CTSC_OP_WR, 9'h100, 8'hff);
    cmp(9'h000, 8'ha5, 2'h2);
    cmp(9'h000, 8'ha4, 2'h0);
    cmp(9'h1ff, 8'h5a, 2'h2);
    cmp(9'h100, 8'hff, 2'h2);
    cmp(9'h001, 8'h00, 2'h2);
  endtask
  task automatic s_reclear();
    do_op(CTSC_OP_CLR, 9'h000, 8'h00);
    do_op(CTSC_OP_NONE, 9'h000, 8'ha5);
    cmp(9'h000, 8'ha5, 2'h0);
    cmp(9'h1ff, 8'h00, 2'h2);
  endtask
  // forced error line must read as a parity fault
  task automatic s_force();
    force_err <= 1'b1;
    cmp(9'h003, 8'h00, 2'h1);
    force_err <= 1'b0;
    cmp(9'h003, 8'h00, 2'h2);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    s_clear();
    s_write();
    s_reclear();
    s_force();
    give_verdict();
  end
endmodule
`default_nettype wire
